// ===== rtc_defs.vh
// Register offsets, field positions, reset values and counts of the backup-domain calendar clock
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH
`define OFS_TIME 13'h0000
`define OFS_DATE 13'h0004
`define OFS_CTRL 13'h0008
`define OFS_STAT 13'h000C
`define OFS_PRER 13'h0010
`define OFS_WUTR 13'h0014
`define OFS_ALRA 13'h0018
`define OFS_ALRB 13'h001C
`define OFS_ASSA 13'h0020
`define OFS_ASSB 13'h0024
`define OFS_SSR 13'h0028
`define OFS_MASK 13'h002C
`define OFS_BKP0 13'h0050
`define BKP_COUNT 20
`define BKSRAM_BASE 13'h1000
`define BKSRAM_WORDS 1024
`define CTRL_SRC_LSB 0
`define CTRL_WUCK_LSB 2
`define CTRL_FMT12 6
`define CTRL_ALRA_EN 8
`define CTRL_ALRB_EN 9
`define CTRL_WUT_EN 10
`define CTRL_CAL_EN 11
`define CTRL_BKSRAM_EN 12
`define SRC_LSE 2'h0
`define SRC_LSI 2'h1
`define SRC_FAST 2'h2
`define EV_ALRA 0
`define EV_ALRB 1
`define EV_WUT 2
`define EV_TAMP 3
`define EV_TSTAMP 4
`define PREDIV_A_RST 7'h7F
`define PREDIV_S_RST 13'h00FF
`define FAST_DIV_LAST 7'h7F
`define CAL_DIV_LAST 5'h1F
`define WUTR_RST 16'hFFFF
`define TIME_RST 21'h000000
// Packed as {year, weekday, month, date}: year 00, weekday 1, month 01, date 01
`define DATE_RST 22'h000841
`endif

// ===== rtc_core.v
// Backup-domain calendar clock with alarms, wakeup timer, backup registers and backup SRAM on AHB-Lite
`timescale 1ns/10ps
`include "rtc_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Seconds, minutes, hours, weekday, date, month and year counters kept in BCD.
// - Software selects 12-hour with AM/PM flag or 24-hour counting.
// - Date rolls over after 28, 29, 30 or 31 days; February has 29 in leap years.
// - Sub-second count readable as plain binary beside the calendar.
// - Time base from crystal clock, internal RC clock or fast external clock divided by 128.
// - Optional 512 Hz calibration output derived from the time base.
// - Two alarms compare programmed fields with time; each field can be masked.
// - Alarms hold sub-second, second, minute, hour, day and date match values.
// - 16-bit auto-reload wakeup downcounter with selectable resolution raises periodic events.
// - 20-bit prescaler; reset values give one tick per second from 32.768 kHz.
// - Alarm and wakeup events can wake the device from Stop and Standby.
// - 4 KB backup SRAM, disabled after reset, usable only once enabled.
// - Twenty 32-bit retained backup registers, 80 bytes in total.
// - System reset, power reset and Standby wakeup leave backup registers intact.
// - Backup registers and enabled backup SRAM survive Standby.
// - Alarm, wakeup, tamper and timestamp events can each end Standby.
// - Those events drive external event lines to wake the device from Stop.
// - On battery supply only, no event ends the battery state.
module rtc_core (
   input wire i_ref_clk, // 100 MHz system clock
   input wire i_rst_n, // Asynchronous reset, active low
   input wire i_hsel, // AHB slave select
   input wire [12:0] i_haddr, // AHB byte address
   input wire [1:0] i_htrans, // AHB transfer type
   input wire i_hwrite, // AHB write
   input wire [2:0] i_hsize, // AHB size, word only
   input wire [31:0] i_hwdata, // AHB write data
   input wire i_hready, // AHB bus ready
   output wire o_hreadyout, // AHB slave ready
   output wire o_hresp, // AHB response, always OKAY
   output reg [31:0] o_hrdata, // AHB read data
   input wire i_lse_clk, // 32.768 kHz crystal clock pin
   input wire i_lsi_clk, // Internal low-speed RC clock
   input wire i_fast_external_oscillator, // Fast external clock, divided by 128
   input wire i_tamper, // Tamper event pin
   input wire i_tstamp, // Timestamp event pin
   input wire i_battery_supply_input, // High while running from battery only
   output reg o_calib_out, // 512 Hz calibration output
   output wire o_irq, // Level interrupt
   output wire o_wakeup, // Wake request to the low-power controller
   output reg [4:0] o_external_event_line // One-cycle event pulses
);

////////////////////////////////////////////////////////////////////////////////
function [7:0] bcd_inc;
   input [7:0] v;
   begin
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   end
endfunction

function [5:0] month_last;
   input [4:0] mon;
   input [7:0] yr;
   reg leap;
   begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
         (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
         5'h02: month_last = leap ? 6'h29 : 6'h28;
         5'h04, 5'h06, 5'h09, 5'h11: month_last = 6'h30;
         default: month_last = 6'h31;
      endcase
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin inputs: three flops, a change counts once stages two and three agree
reg [4:0] sync1, sync2, sync3, stable, stable_d;
wire [4:0] pins = {i_tstamp, i_tamper, i_fast_external_oscillator, i_lsi_clk, i_lse_clk};
wire [4:0] rise = stable & ~stable_d;
always @(posedge i_ref_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
      stable <= 5'h00;
      stable_d <= 5'h00;
   end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      stable <= (sync2 & sync3) | (stable & (sync2 ^ sync3));
      stable_d <= stable;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [31:0] ctrl, alra, alrb, assa, assb;
reg [6:0] prediv_a, apre;
reg [12:0] prediv_s, ssub;
reg [15:0] wutr, wut_cnt;
reg [4:0] status, mask;
reg [6:0] sec, mins;
reg [5:0] hour;
reg pm;
reg [5:0] date;
reg [4:0] month;
reg [2:0] wday;
reg [7:0] year;
reg [6:0] fast_div;
reg [4:0] cal_div;
reg [3:0] wut_div;
reg alra_m_d, alrb_m_d;
reg [31:0] bkp [0:`BKP_COUNT-1];
reg [31:0] bksram [0:`BKSRAM_WORDS-1];
reg wr_q;
reg wut_tick;
reg [12:0] wr_addr;

wire [1:0] src = ctrl[`CTRL_SRC_LSB+1:`CTRL_SRC_LSB];
wire fmt12 = ctrl[`CTRL_FMT12];
wire fast_tick = rise[2] && fast_div == `FAST_DIV_LAST;
wire src_tick = (src == `SRC_LSE) ? rise[0] : (src == `SRC_LSI) ? rise[1] : (src == `SRC_FAST) ? fast_tick : 1'b0;
wire apre_tick = src_tick && apre == 7'h00;
wire sec_tick = apre_tick && ssub == 13'h0000;

////////////////////////////////////////////////////////////////////////////////
// Bus decode; single wait-free slave, read data registered in the address phase
wire req = i_hsel && i_hready && i_htrans[1];
wire in_sram = i_haddr >= `BKSRAM_BASE;
wire [9:0] sram_idx = i_haddr[11:2];
wire [12:0] bkp_rel = i_haddr - `OFS_BKP0;
wire in_bkp = i_haddr >= `OFS_BKP0 && bkp_rel[12:2] < `BKP_COUNT;
wire [12:0] wbkp_rel = wr_addr - `OFS_BKP0;
wire w_bkp = wr_addr >= `OFS_BKP0 && wbkp_rel[12:2] < `BKP_COUNT;
wire w_sram = wr_addr >= `BKSRAM_BASE;
wire wr_time = wr_q && wr_addr == `OFS_TIME;
wire wr_date = wr_q && wr_addr == `OFS_DATE;
wire [4:0] stat_clr = (wr_q && wr_addr == `OFS_STAT) ? i_hwdata[4:0] : 5'h00;
wire sram_en = ctrl[`CTRL_BKSRAM_EN];
assign o_hreadyout = 1'b1;
assign o_hresp = 1'b0;

always @(posedge i_ref_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      wr_q <= 1'b0;
      wr_addr <= 13'h0000;
      o_hrdata <= 32'h00000000;
   end else begin
      wr_q <= req && i_hwrite;
      wr_addr <= {i_haddr[12:2], 2'b00};
      if (req && !i_hwrite) begin
         if (in_sram) begin
            o_hrdata <= sram_en ? bksram[sram_idx] : 32'h00000000;
         end else if (in_bkp) begin
            o_hrdata <= bkp[bkp_rel[6:2]];
         end else begin
            case ({i_haddr[12:2], 2'b00})
               `OFS_TIME: o_hrdata <= {9'h000, pm, hour, 1'b0, mins, 1'b0, sec};
               `OFS_DATE: o_hrdata <= {8'h00, year, wday, month, 2'b00, date};
               `OFS_CTRL: o_hrdata <= ctrl;
               `OFS_STAT: o_hrdata <= {27'h0000000, status};
               `OFS_PRER: o_hrdata <= {9'h000, prediv_a, 3'h0, prediv_s};
               `OFS_WUTR: o_hrdata <= {16'h0000, wutr};
               `OFS_ALRA: o_hrdata <= alra;
               `OFS_ALRB: o_hrdata <= alrb;
               `OFS_ASSA: o_hrdata <= assa;
               `OFS_ASSB: o_hrdata <= assb;
               `OFS_SSR: o_hrdata <= {19'h00000, ssub};
               `OFS_MASK: o_hrdata <= {27'h0000000, mask};
               default: o_hrdata <= 32'h00000000;
            endcase
         end
      end
   end
end

// Retained storage has no reset: system resets and Standby wakeup keep it
always @(posedge i_ref_clk) begin
   if (wr_q && w_bkp) begin
      bkp[wbkp_rel[6:2]] <= i_hwdata;
   end
   if (wr_q && w_sram && sram_en) begin
      bksram[wr_addr[11:2]] <= i_hwdata;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Control registers, prescaler and wakeup timer
always @(posedge i_ref_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      ctrl <= 32'h00000000;
      alra <= 32'h00000000;
      alrb <= 32'h00000000;
      assa <= 32'h00000000;
      assb <= 32'h00000000;
      prediv_a <= `PREDIV_A_RST;
      prediv_s <= `PREDIV_S_RST;
      wutr <= `WUTR_RST;
      mask <= 5'h00;
      apre <= `PREDIV_A_RST;
      ssub <= `PREDIV_S_RST;
      fast_div <= 7'h00;
      cal_div <= 5'h00;
      o_calib_out <= 1'b0;
      wut_div <= 4'h0;
      wut_cnt <= `WUTR_RST;
   end else begin
      if (wr_q) begin
         case (wr_addr)
            `OFS_CTRL: ctrl <= i_hwdata;
            `OFS_ALRA: alra <= i_hwdata;
            `OFS_ALRB: alrb <= i_hwdata;
            `OFS_ASSA: assa <= i_hwdata;
            `OFS_ASSB: assb <= i_hwdata;
            `OFS_PRER: begin
               prediv_a <= i_hwdata[22:16];
               prediv_s <= i_hwdata[12:0];
            end
            `OFS_WUTR: wutr <= i_hwdata[15:0];
            `OFS_MASK: mask <= i_hwdata[4:0];
            default: ;
         endcase
      end
      if (rise[2]) begin
         fast_div <= fast_div + 7'h01;
      end
      if (src_tick) begin
         apre <= (apre == 7'h00) ? prediv_a : apre - 7'h01;
         cal_div <= cal_div + 5'h01;
         if (cal_div == `CAL_DIV_LAST) begin
            o_calib_out <= ctrl[`CTRL_CAL_EN] & ~o_calib_out;
         end
         wut_div <= wut_div + 4'h1;
      end
      if (apre_tick) begin
         ssub <= (ssub == 13'h0000) ? prediv_s : ssub - 13'h0001;
      end
      if (!ctrl[`CTRL_WUT_EN]) begin
         wut_cnt <= wutr;
      end else if (wut_tick) begin
         wut_cnt <= (wut_cnt == 16'h0000) ? wutr : wut_cnt - 16'h0001;
      end
   end
end

// Resolution: source/16, /8, /4, /2, or the one-second tick
always @* begin
   case (ctrl[`CTRL_WUCK_LSB+2:`CTRL_WUCK_LSB])
      3'h0: wut_tick = src_tick && wut_div[3:0] == 4'hF;
      3'h1: wut_tick = src_tick && wut_div[2:0] == 3'h7;
      3'h2: wut_tick = src_tick && wut_div[1:0] == 2'h3;
      3'h3: wut_tick = src_tick && wut_div[0];
      default: wut_tick = sec_tick;
   endcase
end

////////////////////////////////////////////////////////////////////////////////
// Calendar; a bus write to time or date wins over a tick in the same cycle
wire sec_wrap = sec == 7'h59;
wire min_wrap = mins == 7'h59;
wire hour_wrap = fmt12 ? (hour == 6'h11 && pm) : hour == 6'h23;
wire date_wrap = date == month_last(month, year);
wire [7:0] sec_inc = bcd_inc({1'b0, sec});
wire [7:0] min_inc = bcd_inc({1'b0, mins});
wire [7:0] hour_inc = bcd_inc({2'b00, hour});
wire [7:0] date_inc = bcd_inc({2'b00, date});
wire [7:0] month_inc = bcd_inc({3'b000, month});
always @(posedge i_ref_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      {pm, hour, mins, sec} <= `TIME_RST;
      {year, wday, month, date} <= `DATE_RST;
   end else begin
      if (wr_time) begin
         {pm, hour, mins, sec} <= {i_hwdata[22:16], i_hwdata[14:8], i_hwdata[6:0]};
      end else if (sec_tick) begin
         sec <= sec_wrap ? 7'h00 : sec_inc[6:0];
         if (sec_wrap) begin
            mins <= min_wrap ? 7'h00 : min_inc[6:0];
            if (min_wrap) begin
               if (fmt12) begin
                  hour <= (hour == 6'h12) ? 6'h01 : hour_inc[5:0];
                  if (hour == 6'h11) begin
                     pm <= ~pm;
                  end
               end else begin
                  hour <= hour_wrap ? 6'h00 : hour_inc[5:0];
               end
            end
         end
      end
      if (wr_date) begin
         {year, wday, month, date} <= {i_hwdata[23:13], i_hwdata[12:8], i_hwdata[5:0]};
      end else if (sec_tick && sec_wrap && min_wrap && hour_wrap) begin
         wday <= (wday == 3'h7) ? 3'h1 : wday + 3'h1;
         date <= date_wrap ? 6'h01 : date_inc[5:0];
         if (date_wrap) begin
            month <= (month == 5'h12) ? 5'h01 : month_inc[4:0];
            if (month == 5'h12) begin
               year <= (year == 8'h99) ? 8'h00 : bcd_inc(year);
            end
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Alarms: field [7]/[15]/[23]/[31] masks second/minute/hour/day, [30] picks weekday
function alarm_hit;
   input [31:0] a;
   input [31:0] s;
   begin
      alarm_hit = (a[7] || a[6:0] == sec) && (a[15] || a[14:8] == mins) &&
         (a[23] || (a[21:16] == hour && (!fmt12 || a[22] == pm))) &&
         (a[31] || (a[30] ? a[26:24] == wday : a[29:24] == date)) &&
         (s[24] || s[12:0] == ssub);
   end
endfunction

wire alra_m = ctrl[`CTRL_ALRA_EN] && alarm_hit(alra, assa);
wire alrb_m = ctrl[`CTRL_ALRB_EN] && alarm_hit(alrb, assb);
wire [4:0] events = {rise[4], rise[3], wut_tick && ctrl[`CTRL_WUT_EN] && wut_cnt == 16'h0000,
   alrb_m && !alrb_m_d, alra_m && !alra_m_d};
wire pending = |(status & mask);
assign o_irq = pending;
// Battery-only operation must never be ended by the clock's own events
assign o_wakeup = pending && !i_battery_supply_input;

always @(posedge i_ref_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      status <= 5'h00;
      alra_m_d <= 1'b0;
      alrb_m_d <= 1'b0;
      o_external_event_line <= 5'h00;
   end else begin
      alra_m_d <= alra_m;
      alrb_m_d <= alrb_m;
      status <= (status & ~stat_clr) | events;
      o_external_event_line <= i_battery_supply_input ? 5'h00 : events;
   end
end

endmodule // rtc_core

// ===== rtc_osc_model.sv
// Stand-in oscillators feeding the time base of the calendar core
`timescale 1ns/10ps
module rtc_osc_model (
   output logic o_lse_clk, // Crystal clock
   output logic o_lsi_clk, // RC clock
   output logic o_fast_clk // Fast clock for the divide-by-128 path
);
   // Rates scaled up so a tick takes hundreds of cycles, still far below the sampling limit
   initial begin
      o_lse_clk = 1'b0;
      o_lsi_clk = 1'b0;
      o_fast_clk = 1'b0;
   end
   always #100.3 o_lse_clk = ~o_lse_clk;
   always #117.1 o_lsi_clk = ~o_lsi_clk;
   always #40.7 o_fast_clk = ~o_fast_clk;
endmodule // rtc_osc_model

// ===== rtc_core_properties.sv
// Concurrent checks on the ports of the calendar clock core
`timescale 1ns/10ps
`include "rtc_defs.vh"
module rtc_core_properties (
   input wire i_ref_clk, // Clock
   input wire i_rst_n, // Reset
   input wire i_hsel, // Select
   input wire [12:0] i_haddr, // Address
   input wire [1:0] i_htrans, // Transfer
   input wire i_hwrite, // Write
   input wire [31:0] i_hwdata, // Write data
   input wire i_hready, // Ready
   input wire [31:0] o_hrdata, // Read data
   input wire i_tamper, // Tamper pin
   input wire i_tstamp, // Stamp pin
   input wire i_battery_supply_input, // Battery only
   input wire o_calib_out, // Calibration
   input wire o_irq, // Interrupt
   input wire o_wakeup, // Wake
   input wire [4:0] o_external_event_line // Events
);
   reg pend;
   reg [12:0] pend_addr;
   reg [12:0] ctrl_sh;
   wire take = i_hsel && i_hready && i_htrans[1];
   wire batt = i_battery_supply_input;
   wire [4:0] ev = o_external_event_line;
   // Control shadow lands on the same edge as the core's own write
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pend <= 1'b0;
         pend_addr <= 13'h0000;
         ctrl_sh <= 13'h0000;
      end else begin
         pend <= take && i_hwrite;
         pend_addr <= i_haddr;
         if (pend && pend_addr == `OFS_CTRL) ctrl_sh <= i_hwdata[12:0];
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   a_wake_battery: assert property (batt |-> !o_wakeup)
      else $error("wake on battery");
   a_wake_irq: assert property (!batt |-> o_wakeup == o_irq)
      else $error("wake differs from irq");
   a_event_quiet: assert property (batt && $past(batt) |-> ev == 5'h00)
      else $error("event on battery");
   a_event_pulse: assert property (|ev |=> (ev & $past(ev)) == 5'h00)
      else $error("event longer than a cycle");
   a_tamper_event: assert property ($rose(i_tamper) && !batt |-> ##[2:8] (ev[3] || batt))
      else $error("tamper event missing");
   a_stamp_event: assert property ($rose(i_tstamp) && !batt |-> ##[2:8] (ev[4] || batt))
      else $error("stamp event missing");
   a_bksram_off: assert property (take && !i_hwrite && i_haddr[12] && !ctrl_sh[`CTRL_BKSRAM_EN] |=> o_hrdata == 32'h0)
      else $error("backup memory read while off");
   a_calib_quiet: assert property (!ctrl_sh[`CTRL_CAL_EN] && !o_calib_out |=> !o_calib_out || ctrl_sh[`CTRL_CAL_EN])
      else $error("calibration toggles while off");
   c_tamper: cover property (ev[3]);
   c_wake: cover property (o_wakeup);
   c_alarm: cover property (ev[0]);
   c_bksram: cover property (take && i_haddr[12] && ctrl_sh[`CTRL_BKSRAM_EN]);
endmodule // rtc_core_properties
bind rtc_core rtc_core_properties i_rtc_core_properties (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
   .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .o_hrdata(o_hrdata), .i_tamper(i_tamper), .i_tstamp(i_tstamp), .i_battery_supply_input(i_battery_supply_input),
   .o_calib_out(o_calib_out), .o_irq(o_irq), .o_wakeup(o_wakeup), .o_external_event_line(o_external_event_line));

// ===== rtc_core_tb.sv
// Self-checking testbench of the calendar clock core
`timescale 1ns/10ps
`include "rtc_defs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("FAIL %s exp %h got %h", n, e, g); end end
module rtc_core_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic tamper = 1'b0;
   logic tstamp = 1'b0;
   logic batt = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [12:0] haddr = 13'h0000;
   logic [31:0] hwdata = 32'h0, rd, v;
   logic [31:0] bk[20];
   logic [7:0] m, y, d, nm;
   logic [2:0] wd, src;
   logic [12:0] ra[7] = '{`OFS_TIME, `OFS_DATE, `OFS_CTRL, `OFS_STAT, `OFS_PRER, `OFS_WUTR, 13'h0040};
   logic [31:0] re[7] = '{32'h0, 32'h002101, 32'h0, 32'h0, 32'h007F00FF, 32'hFFFF, 32'h0};
   logic [7:0] cm[4] = '{8'h02, 8'h02, 8'h02, 8'h12};
   logic [7:0] cy[4] = '{8'h04, 8'h01, 8'h00, 8'h09};
   logic [2:0] cs[4] = '{3'h0, 3'h1, 3'h2, 3'h0};
   wire hrdy, hresp, calib, irq, wake, lse, lsi, fast;
   wire [31:0] hrdata;
   wire [4:0] ev;
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   rtc_osc_model i_rtc_osc_model (.o_lse_clk(lse), .o_lsi_clk(lsi), .o_fast_clk(fast));
   rtc_core i_rtc_core (.i_ref_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp),
      .o_hrdata(hrdata), .i_lse_clk(lse), .i_lsi_clk(lsi), .i_fast_external_oscillator(fast), .i_tamper(tamper),
      .i_tstamp(tstamp), .i_battery_supply_input(batt), .o_calib_out(calib), .o_irq(irq), .o_wakeup(wake),
      .o_external_event_line(ev));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         err_count++;
         summarize();
      end
   end
   ////////////////////////////////////////
   task automatic bus(input logic w, input logic [12:0] a, input logic [31:0] dat);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= dat;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rc(input logic [12:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK($sformatf("addr %h", a), e, rd)
   endtask
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task summarize;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic logic [7:0] bcd_inc(input logic [7:0] x);
      return (x[3:0] == 4'h9) ? {x[7:4] + 4'h1, 4'h0} : x + 8'h01;
   endfunction
   function automatic logic [7:0] last_day(input logic [7:0] mo, input logic [7:0] yr);
      case (mo)
         8'h02: return ((yr[7:4] * 10 + yr[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
         default: return 8'h31;
      endcase
   endfunction
   ////////////////////////////////////////
   initial begin
      void'($urandom(32'hB39D));
      do_reset();
      foreach (ra[i]) rc(ra[i], re[i]);
      for (int i = 0; i < `BKP_COUNT; i++) begin
         bk[i] = $urandom;
         bus(1'b1, `OFS_BKP0 + 13'(4 * i), bk[i]);
      end
      v = $urandom;
      bus(1'b1, `BKSRAM_BASE, v);
      rc(`BKSRAM_BASE, 32'h0);
      bus(1'b1, `OFS_CTRL, 32'h1000);
      bus(1'b1, `BKSRAM_BASE + 13'hFFC, v);
      rc(`BKSRAM_BASE + 13'hFFC, v);
      do_reset();
      rc(`BKSRAM_BASE + 13'hFFC, 32'h0);
      bus(1'b1, `OFS_CTRL, 32'h1000);
      rc(`BKSRAM_BASE + 13'hFFC, v);
      for (int i = 0; i < `BKP_COUNT; i++) rc(`OFS_BKP0 + 13'(4 * i), bk[i]);
      // Short prescaler so a tick takes eight source edges
      bus(1'b1, `OFS_PRER, 32'h7);
      for (int i = 0; i < 6; i++) begin
         m = (i < 4) ? cm[i] : 8'(1 + $urandom % 12);
         if (m > 8'h09 && i > 3) m = m + 8'h06;
         y = (i < 4) ? cy[i] : {4'($urandom % 9), 4'($urandom % 10)};
         src = (i < 4) ? cs[i] : 3'($urandom % 2);
         wd = 3'(1 + $urandom % 7);
         d = last_day(m, y);
         nm = (m == 8'h12) ? 8'h01 : bcd_inc(m);
         bus(1'b1, `OFS_CTRL, (i == 0) ? 32'h43 : 32'h3);
         bus(1'b1, `OFS_TIME, (i == 0) ? 32'h00515959 : 32'h00235959);
         bus(1'b1, `OFS_DATE, {8'h0, y, wd, m[4:0], d});
         bus(1'b1, `OFS_CTRL, (i == 0) ? 32'h40 : {29'h0, src});
         rd = {24'h0, d};
         for (int k = 0; k < 5000 && rd[7:0] == d; k++) bus(1'b0, `OFS_DATE, 32'h0);
         bus(1'b1, `OFS_CTRL, 32'h3);
         rc(`OFS_TIME, (i == 0) ? 32'h00120000 : 32'h0);
         rc(`OFS_DATE, {8'h0, (m == 8'h12) ? bcd_inc(y) : y, (wd == 3'h7) ? 3'h1 : wd + 3'h1, nm[4:0], 8'h01});
      end
      // Alarm on second 05 only; calibration output runs meanwhile
      bus(1'b1, `OFS_TIME, 32'h3);
      bus(1'b1, `OFS_ALRA, 32'h80808005);
      bus(1'b1, `OFS_ASSA, 32'h01000000);
      bus(1'b1, `OFS_MASK, 32'h1);
      bus(1'b1, `OFS_CTRL, 32'h900);
      for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(negedge clk);
      `CHK("alarm irq", 1'b1, irq)
      rc(`OFS_TIME, 32'h5);
      rc(`OFS_STAT, 32'h1);
      bus(1'b1, `OFS_STAT, 32'h1);
      bus(1'b0, `OFS_SSR, 32'h0);
      `CHK("ssr high bits", 29'h0, rd[31:3])
      `CHK("hresp", 1'b0, hresp)
      for (int k = 0; k < 1500 && calib !== 1'b1; k++) @(negedge clk);
      `CHK("calib", 1'b1, calib)
      bus(1'b1, `OFS_WUTR, 32'h2);
      bus(1'b1, `OFS_MASK, 32'h4);
      bus(1'b1, `OFS_CTRL, 32'h410);
      for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(negedge clk);
      `CHK("irq", 1'b1, irq)
      `CHK("wake", 1'b1, wake)
      @(posedge clk);
      batt <= 1'b1;
      repeat (2) @(negedge clk);
      `CHK("battery wake", 1'b0, wake)
      @(posedge clk);
      batt <= 1'b0;
      bus(1'b1, `OFS_CTRL, 32'h0);
      bus(1'b1, `OFS_MASK, 32'h0);
      @(negedge clk);
      `CHK("masked irq", 1'b0, irq)
      rc(`OFS_STAT, 32'h4);
      bus(1'b1, `OFS_STAT, 32'h4);
      rc(`OFS_STAT, 32'h0);
      bus(1'b1, `OFS_MASK, 32'h18);
      for (int b = 3; b < 5; b++) begin
         if (b == 3) tamper <= 1'b1;
         else tstamp <= 1'b1;
         for (int k = 0; k < 20 && ev[b] !== 1'b1; k++) @(negedge clk);
         `CHK("event line", 1'b1, ev[b])
         `CHK("event irq", 1'b1, irq)
         rc(`OFS_STAT, 32'(1 << b));
         bus(1'b1, `OFS_STAT, 32'h18);
         if (b == 3) tamper <= 1'b0;
         else tstamp <= 1'b0;
      end
      summarize();
   end
endmodule // rtc_core_tb
